/* File: hw/pll_map.vh */
// Register map, field widths and reset values of the PLL divider and spread block
`ifndef PLL_MAP_VH
`define PLL_MAP_VH
`define PLL_CFG_BASE 8'h00
`define BANK_BASE 8'h10
`define STATUS_ADDR 8'h20
`define LAST_CTRL_ADDR 8'h4C
`define LAST_LOOP_ADDR 8'h50
`define SS_CTRL_ADDR 8'hAC
`define SS_SAMP_LO_ADDR 8'hB0
`define SS_SAMP_HI_ADDR 8'hB4
`define SS_STATUS_ADDR 8'hB8
`define REF_DIV_W 7
`define FB_W 12
`define FRAC_W 4
`define MULT_W 14
`define Q_W 7
`define Q_DISABLE 7'h7F
`define OFF_LOW 2'h0
`define OFF_HIGH 2'h1
`define STEP_EXTRA 5'h02
`define SAMPLE_COUNT 12
`define OFFSET_W 6
`define PLL_CFG_RESET 24'h000001
`define BANK_RESET 10'h000
`define LFSR_SEED 15'h0001
`endif

/* File: hw/pll_divider_spread_modulator.v */
// PLL divider settings, output dividers and spread-spectrum modulator with APB access
// Functional notes
// - Each PLL has a 7-bit reference divide and 12-bit feedback divide setting.
// - Output frequency is input times multiplier over reference divide over output divide.
// - First PLL multiplier is 2N+A+1 when A nonzero, else 2N.
// - Other PLLs use the feedback count directly as multiplier.
// - Undivided output has no divider; each other bank has prescale and 7-bit divide.
// - All-ones: off or /1; otherwise /2 or /((Q+2)*2) by prescale.
// - Disabled divider drives high, low or high-Z per off-state select, no clocks.
// - Spread is active whenever the step-period setting is nonzero.
// - Step lasts setting plus two detector cycles; settings 5 to 14 only.
// - Quadrant uses twice the setting samples; settings 1 to 6 only.
// - Four mirrored quadrants built from the same sample sequence.
// - Zero offset gives centre spread; nonzero centres on M minus one plus offset.
// - Twelve 4-bit delta samples held; only the selected count is used.
// - Waveform starts at offset, each point adds the next delta to the previous.
// - Dither bit randomizes the least significant bit of the sample input.
// - Amplitude-double bit doubles the accumulated total.
// - First PLL spread settings sit between addresses 0xAC and 0xBD.
// - Fourth PLL spread enabled by its bit; settings between 0x4C and 0x85.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pll_map.vh"

module pll_divider_spread_modulator #(
    parameter NB = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // VCO levels: bit 0 undivided path, bit i+1 bank i
    input wire [NB:0] vco_clk,
    // Clock outputs
    output reg undivided_output,
    output wire [NB-1:0] bank_out,
    output wire [NB-1:0] bank_oe,
    // Loop settings to the analogue PLLs
    output reg [4*`REF_DIV_W-1:0] ref_divide,
    output reg [4*`MULT_W-1:0] pll_mult,
    output reg signed [8:0] spread_frac,
    output reg spread_active,
    output reg last_pll_spread_enable,
    output reg [7:0] last_pll_spread_ref_divide,
    output reg [15:0] last_pll_spread_loop_count
);

    reg [23:0] pll_cfg_reg [0:3];
    reg [9:0] bank_reg [0:NB-1];
    reg [17:0] ss_ctrl_reg;
    reg [47:0] samp_reg;
    reg [31:0] rd_data;
    reg rd_ok;
    reg [6:0] pfd_cnt_reg;
    reg pfd_tick_reg;
    reg [4:0] step_cnt_reg;
    reg [3:0] idx_reg;
    reg [1:0] quad_reg;
    reg signed [7:0] acc_reg;
    reg [14:0] lfsr_reg;
    integer k;
    integer m;

    // Address pages of the per-PLL and per-bank words
    localparam [3:0] CFG_PAGE = 4'h0;
    localparam [3:0] BANK_PAGE = 4'h1;

    wire [3:0] step_set = ss_ctrl_reg[3:0];
    wire [2:0] quad_set = ss_ctrl_reg[6:4];
    wire [5:0] offset = ss_ctrl_reg[13:8];
    wire lsb_dither_enable = ss_ctrl_reg[16];
    wire amplitude_double = ss_ctrl_reg[17];
    wire [4:0] step_len = {1'b0, step_set} + `STEP_EXTRA;
    wire [3:0] nssc = {quad_set, 1'b0};
    wire access = psel & penable & ~pready;
    wire wr_en = psel & penable & pready & pwrite;
    wire [1:0] sel = paddr[3:2];

    // Mirrored quadrants walk the same samples forward then backward
    reg [3:0] idx_rd;
    always @* begin
        if (quad_reg[0]) begin
            idx_rd = nssc - 4'h1 - idx_reg;
        end else begin
            idx_rd = idx_reg;
        end
    end

    // Explicit sample mux keeps the index arithmetic narrow
    reg [3:0] samp_raw;
    always @* begin
        case (idx_rd)
            4'h0: samp_raw = samp_reg[3:0];
            4'h1: samp_raw = samp_reg[7:4];
            4'h2: samp_raw = samp_reg[11:8];
            4'h3: samp_raw = samp_reg[15:12];
            4'h4: samp_raw = samp_reg[19:16];
            4'h5: samp_raw = samp_reg[23:20];
            4'h6: samp_raw = samp_reg[27:24];
            4'h7: samp_raw = samp_reg[31:28];
            4'h8: samp_raw = samp_reg[35:32];
            4'h9: samp_raw = samp_reg[39:36];
            4'hA: samp_raw = samp_reg[43:40];
            4'hB: samp_raw = samp_reg[47:44];
            default: samp_raw = 4'h0;
        endcase
    end

    // Dither flips only the sample lsb, so the walk may drift by one per step
    wire [3:0] samp = samp_raw ^ {3'b000, lsb_dither_enable & lfsr_reg[0]};

    // Quadrants 0 and 3 climb, 1 and 2 fall
    reg quad_up;
    always @* begin
        case (quad_reg)
            2'd0: quad_up = 1'b1;
            2'd1: quad_up = 1'b0;
            2'd2: quad_up = 1'b0;
            2'd3: quad_up = 1'b1;
            default: quad_up = 1'b1;
        endcase
    end
    wire signed [7:0] acc_next = quad_up ? acc_reg + $signed({4'h0, samp})
                                        : acc_reg - $signed({4'h0, samp});

    // Doubling shifts the whole accumulated point, not each sample
    reg signed [8:0] acc_scaled;
    always @* begin
        if (amplitude_double) begin
            acc_scaled = {acc_reg, 1'b0};
        end else begin
            acc_scaled = {acc_reg[7], acc_reg};
        end
    end

    // Register read decode
    always @* begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        if (paddr[7:4] == CFG_PAGE) begin
            rd_data = {8'h00, pll_cfg_reg[sel]};
        end else if (paddr[7:4] == BANK_PAGE && sel < NB) begin
            rd_data = {22'h000000, bank_reg[sel]};
        end else begin
            case (paddr)
                `STATUS_ADDR: rd_data = {26'h0000000, spread_active, last_pll_spread_enable, 4'h0};
                `LAST_CTRL_ADDR: rd_data = {23'h000000, last_pll_spread_enable, last_pll_spread_ref_divide};
                `LAST_LOOP_ADDR: rd_data = {16'h0000, last_pll_spread_loop_count};
                `SS_CTRL_ADDR: rd_data = {14'h0000, ss_ctrl_reg};
                `SS_SAMP_LO_ADDR: rd_data = samp_reg[31:0];
                `SS_SAMP_HI_ADDR: rd_data = {16'h0000, samp_reg[47:32]};
                `SS_STATUS_ADDR: rd_data = {9'h000, quad_reg, idx_reg, acc_reg, spread_frac};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // APB answer one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access & ~rd_ok;
            if (access && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < 4; k = k + 1) begin
                pll_cfg_reg[k] <= `PLL_CFG_RESET;
            end
            for (k = 0; k < NB; k = k + 1) begin
                bank_reg[k] <= `BANK_RESET;
            end
            ss_ctrl_reg <= 18'h00000;
            samp_reg <= 48'h000000000000;
            last_pll_spread_enable <= 1'b0;
            last_pll_spread_ref_divide <= 8'h00;
            last_pll_spread_loop_count <= 16'h0000;
        end else if (wr_en) begin
            if (paddr[7:4] == CFG_PAGE) begin
                pll_cfg_reg[sel] <= pwdata[23:0];
            end else if (paddr[7:4] == BANK_PAGE && sel < NB) begin
                bank_reg[sel] <= pwdata[9:0];
            end else begin
                case (paddr)
                    `LAST_CTRL_ADDR: begin
                        last_pll_spread_enable <= pwdata[8];
                        last_pll_spread_ref_divide <= pwdata[7:0];
                    end
                    `LAST_LOOP_ADDR: last_pll_spread_loop_count <= pwdata[15:0];
                    `SS_CTRL_ADDR: ss_ctrl_reg <= pwdata[17:0];
                    `SS_SAMP_LO_ADDR: samp_reg[31:0] <= pwdata;
                    `SS_SAMP_HI_ADDR: samp_reg[47:32] <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Multipliers and reference divides
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_mult <= {4*`MULT_W{1'b0}};
            ref_divide <= {4*`REF_DIV_W{1'b0}};
        end else begin
            for (m = 0; m < 4; m = m + 1) begin
                ref_divide[m*`REF_DIV_W +: `REF_DIV_W] <= pll_cfg_reg[m][6:0];
                pll_mult[m*`MULT_W +: `MULT_W] <= {2'b00, pll_cfg_reg[m][19:8]};
            end
            if (pll_cfg_reg[0][23:20] != 4'h0) begin
                pll_mult[`MULT_W-1:0] <= {1'b0, pll_cfg_reg[0][19:8], 1'b0}
                    + {10'h000, pll_cfg_reg[0][23:20]} + 14'h0001;
            end else begin
                pll_mult[`MULT_W-1:0] <= {1'b0, pll_cfg_reg[0][19:8], 1'b0};
            end
        end
    end

    // Detector rate enable: input clock over first PLL reference divide
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pfd_cnt_reg <= 7'h00;
            pfd_tick_reg <= 1'b0;
        end else begin
            pfd_tick_reg <= 1'b0;
            if (pll_cfg_reg[0][6:0] == 7'h00) begin
                pfd_cnt_reg <= 7'h00;
            end else if (pfd_cnt_reg >= pll_cfg_reg[0][6:0] - 7'h01) begin
                pfd_cnt_reg <= 7'h00;
                pfd_tick_reg <= 1'b1;
            end else begin
                pfd_cnt_reg <= pfd_cnt_reg + 7'h01;
            end
        end
    end

    // Spread modulator walk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_reg <= 5'h00;
            idx_reg <= 4'h0;
            quad_reg <= 2'd0;
            acc_reg <= 8'sh00;
            lfsr_reg <= `LFSR_SEED;
            spread_frac <= 9'sh000;
            spread_active <= 1'b0;
        end else begin
            spread_active <= (step_set != 4'h0);
            spread_frac <= $signed({3'b000, offset}) + acc_scaled;
            if (step_set == 4'h0 || nssc == 4'h0) begin
                step_cnt_reg <= 5'h00;
                idx_reg <= 4'h0;
                quad_reg <= 2'd0;
                acc_reg <= 8'sh00;
            end else if (pfd_tick_reg) begin
                if (step_cnt_reg >= step_len - 5'h01) begin
                    step_cnt_reg <= 5'h00;
                    acc_reg <= acc_next;
                    lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
                    if (idx_reg >= nssc - 4'h1) begin
                        idx_reg <= 4'h0;
                        quad_reg <= quad_reg + 2'd1;
                    end else begin
                        idx_reg <= idx_reg + 4'h1;
                    end
                end else begin
                    step_cnt_reg <= step_cnt_reg + 5'h01;
                end
            end
        end
    end

    // Undivided path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undivided_output <= 1'b0;
        end else begin
            undivided_output <= vco_clk[0];
        end
    end

    // Output dividers, one per bank
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : bank
            reg prev_reg;
            reg [6:0] cnt_reg;
            reg out_reg;
            reg oe_reg;
            wire [6:0] q = bank_reg[g][6:0];
            wire pm = bank_reg[g][7];
            wire [1:0] off_state_select = bank_reg[g][9:8];
            wire rise = vco_clk[g+1] & ~prev_reg;
            assign bank_out[g] = out_reg;
            assign bank_oe[g] = oe_reg;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_reg <= 1'b0;
                    cnt_reg <= 7'h00;
                    out_reg <= 1'b0;
                    oe_reg <= 1'b0;
                end else begin
                    prev_reg <= vco_clk[g+1];
                    oe_reg <= 1'b1;
                    if (q == `Q_DISABLE && !pm) begin
                        cnt_reg <= 7'h00;
                        out_reg <= (off_state_select == `OFF_HIGH);
                        oe_reg <= (off_state_select == `OFF_LOW) || (off_state_select == `OFF_HIGH);
                    end else if (q == `Q_DISABLE) begin
                        out_reg <= vco_clk[g+1];
                    end else if (rise && !pm) begin
                        out_reg <= ~out_reg;
                    end else if (rise) begin
                        if (cnt_reg >= q + 7'h01) begin
                            cnt_reg <= 7'h00;
                            out_reg <= ~out_reg;
                        end else begin
                            cnt_reg <= cnt_reg + 7'h01;
                        end
                    end
                end
            end
        end
    endgenerate

endmodule // pll_divider_spread_modulator

/* File: verif/vco_source.sv */
// Behavioural source of the VCO levels seen by the output dividers
`timescale 1ns/1ps
module vco_source #(
    parameter NB = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Freezes the levels while high
    input wire halt,
    // VCO levels
    output reg [NB:0] vco_clk
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_clk <= {(NB + 1){1'b0}};
        end else if (!halt) begin
            vco_clk <= ~vco_clk;
        end
    end
endmodule // vco_source

/* File: verif/pll_divider_spread_modulator_assertions.sv */
// Port assertions of the PLL divider and spread block
`timescale 1ns/1ps
module pll_divider_spread_modulator_assertions #(
    parameter NB = 4
) (
    // Clock, reset and APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    // Clocks and settings
    input wire [NB:0] vco_clk,
    input wire undivided_output,
    input wire [NB-1:0] bank_oe,
    input wire [55:0] pll_mult,
    input wire spread_active,
    input wire last_pll_spread_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_done = psel && penable && pwrite && pready;
    wire wr_cfg = wr_done && paddr < 8'h10;
    wire wr_bank = wr_done && paddr[7:4] == 4'h1;
    wire wr_ss = wr_done && paddr == 8'hAC;
    wire wr_last = wr_done && paddr == 8'h4C;
    sequence s_setup_access;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_access_answer: assert property (s_setup_access |=> s_answer) else $error("no single ready pulse");
    a_ready_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
        else $error("ready without access");
    a_error_ready: assert property (pslverr |-> pready) else $error("error outside ready");
    a_undiv_follow: assert property ($past(presetn) |-> undivided_output == $past(vco_clk[0]))
        else $error("undivided output not following");
    a_mult_on_write: assert property ($changed(pll_mult) |-> $past(wr_cfg) || $past(wr_cfg, 2))
        else $error("multiplier changed without write");
    a_active_on_write: assert property ($changed(spread_active) |-> $past(wr_ss) || $past(wr_ss, 2))
        else $error("spread state changed without write");
    a_last_on_write: assert property ($changed(last_pll_spread_enable) |-> $past(wr_last) || $past(wr_last, 2))
        else $error("last spread enable changed without write");
    a_oe_on_write: assert property ($changed(bank_oe) && $past(presetn, 3) |-> $past(wr_bank) || $past(wr_bank, 2))
        else $error("output enable changed without write");
endmodule // pll_divider_spread_modulator_assertions

bind pll_divider_spread_modulator pll_divider_spread_modulator_assertions #(.NB(NB)) u_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .vco_clk(vco_clk), .undivided_output(undivided_output),
    .bank_oe(bank_oe), .pll_mult(pll_mult), .spread_active(spread_active),
    .last_pll_spread_enable(last_pll_spread_enable)
);

/* File: verif/tb_pll_divider_spread_modulator.sv */
// Self-checking bench of the PLL divider and spread block
`timescale 1ns/1ps
module tb_pll_divider_spread_modulator;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg halt = 1'b0;
    reg [1:0] bsel = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, undivided_output, spread_active, last_pll_spread_enable;
    wire [4:0] vco_clk;
    wire [3:0] bank_out, bank_oe;
    wire [27:0] ref_divide;
    wire [55:0] pll_mult;
    wire signed [8:0] spread_frac;
    wire [7:0] last_pll_spread_ref_divide;
    wire [15:0] last_pll_spread_loop_count;
    wire mon = bank_out[bsel];
    reg [32:0] exp_q[$];
    reg [15:0] rnd = 16'h002D;
    reg [11:0] fb;
    reg [3:0] fa;
    reg [6:0] rd;
    integer bad_count = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer i, k, p, lo, hi;
    always #20 pclk = ~pclk;
    pll_divider_spread_modulator #(.NB(4)) u_pll_divider_spread_modulator (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vco_clk(vco_clk), .undivided_output(undivided_output),
        .bank_out(bank_out), .bank_oe(bank_oe), .ref_divide(ref_divide), .pll_mult(pll_mult),
        .spread_frac(spread_frac), .spread_active(spread_active), .last_pll_spread_enable(last_pll_spread_enable),
        .last_pll_spread_ref_divide(last_pll_spread_ref_divide),
        .last_pll_spread_loop_count(last_pll_spread_loop_count));
    vco_source #(.NB(4)) u_vco_source (.pclk(pclk), .presetn(presetn), .halt(halt), .vco_clk(vco_clk));
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task check(input [32:0] seen, input [32:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // One APB transfer; the monitor compares the answer
    task apb(input wr, input [7:0] a, input [31:0] d, input [32:0] want);
        begin
            exp_q.push_back(want);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (psel && penable && pready === 1'b1)
            check(pwrite ? {pslverr, 32'h0} : {pslverr, prdata}, exp_q.pop_front());
        if (cycles == 30000) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h00, 0, 33'h000001);
        apb(1, 8'hFC, 32'hFFFFFFFF, 33'h100000000);
        apb(0, 8'hFC, 0, 33'h100000000);
        for (k = 4; k >= 0; k = k - 1) begin
            rnd = lfsr(rnd);
            fb = rnd[11:0];
            fa = (k == 4) ? 4'h0 : (rnd[15:12] | 4'h1);
            rd = (k == 0) ? 7'h01 : rnd[6:0];
            p = k % 4;
            apb(1, 8'(4 * p), {8'h00, fa, fb, 1'b0, rd}, 33'h0);
            repeat (3) @(posedge pclk);
            check(ref_divide[7 * p +: 7], rd);
            check(pll_mult[14 * p +: 14], p ? fb : (fa ? 2 * fb + fa + 1 : 2 * fb));
        end
        apb(0, 8'h00, 0, {9'h000, fa, fb, 1'b0, rd});
        // Divider table: settings and expected period in clock cycles
        for (i = 0; i < 5; i = i + 1) begin
            bsel <= 2'(i);
            k = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : (i == 2) ? 8'h7E : (i == 3) ? 8'h80 : 8'h83;
            apb(1, 8'(16 + 4 * (i % 4)), {24'h0, k[7:0]}, 33'h0);
            @(posedge mon);
            @(posedge mon);
            lo = cycles;
            @(posedge mon);
            check(33'(cycles - lo), (i == 0) ? 2 : (i < 3) ? 4 : (i == 3) ? 8 : 20);
        end
        for (i = 0; i < 8; i = i + 1) begin
            if (i % 2 == 0)
                apb(1, 8'h1C, {22'h0, 2'(i / 2), 8'h7F}, 33'h0);
            repeat (10) @(posedge pclk);
            check(bank_oe[3], i < 4);
            if (i < 4)
                check(bank_out[3], i / 2);
        end
        halt <= 1'b1;
        apb(1, 8'hB0, 32'hFFFFFF53, 33'h0);
        halt <= 1'b0;
        apb(1, 8'hB4, 32'h0000FFFF, 33'h0);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1, 8'hAC, {14'h0, i[0], 3'h0, 6'd10, 1'b0, 3'd1, 4'd5}, 33'h0);
            @(spread_frac);
            @(spread_frac);
            lo = cycles;
            @(spread_frac);
            check(33'(cycles - lo), 7);
            lo = 255;
            hi = -255;
            repeat (70) begin
                @(posedge pclk);
                if (spread_frac < lo) lo = spread_frac;
                if (spread_frac > hi) hi = spread_frac;
            end
            check(33'(hi), 33'(10 + 8 * (i + 1)));
            check(33'(lo), 33'(10 - 8 * (i + 1)));
        end
        apb(0, 8'h20, 0, 33'h20);
        apb(1, 8'hAC, 32'h00000A00, 33'h0);
        repeat (3) @(posedge pclk);
        check({spread_active, spread_frac}, 10);
        rnd = lfsr(rnd);
        apb(1, 8'h4C, {23'h0, 1'b1, rnd[7:0]}, 33'h0);
        apb(1, 8'h50, {16'h0, rnd}, 33'h0);
        apb(0, 8'h20, 0, 33'h10);
        check({last_pll_spread_enable, last_pll_spread_ref_divide, last_pll_spread_loop_count},
            {1'b1, rnd[7:0], rnd});
        end_of_test;
    end
endmodule // tb_pll_divider_spread_modulator
